// >>> include/sfpc_pkg.sv
package sfpc_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 8;
    localparam int OFFS_W = 8;
    localparam int SECT_W = 10;
    localparam int CLK_NS = 10;
    // Pulse timing (ns) and derived cycle counts
    localparam int STROBE_LOW_NS = 100;
    localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_NS = 30;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_NS = 150;
    localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_NS = 50;
    localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
    // Longest gap between loads: round down
    localparam int LOAD_WINDOW_US = 150;
    localparam int LOAD_WINDOW_CYC = LOAD_WINDOW_US * 1000 / CLK_NS;
    localparam int PROG_CYCLE_MS = 10;
    localparam int PROG_CYCLE_CYC = PROG_CYCLE_MS * 100000;
    localparam int POWER_UP_MS = 5;
    localparam int POWER_UP_CYC = POWER_UP_MS * 100000;
    localparam int CNT_W = 24;
    localparam logic [ADDR_W-1:0] LOW_LOCK_ADDR = 18'h00002;
    localparam logic [ADDR_W-1:0] HIGH_LOCK_ADDR = 18'h3fff2;
    localparam logic [DATA_W-1:0] LOCK_OPEN_VAL = 8'hfe;
    localparam logic [DATA_W-1:0] LOCK_SET_VAL = 8'hff;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;

    typedef enum logic [1:0] {SFPC_OP_READ, SFPC_OP_LOAD, SFPC_OP_POLL} sfpc_op_t;

    typedef struct packed {
        sfpc_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic last;
    } sfpc_req_t;

    typedef struct packed {
        logic chip_select_n;
        logic output_drive_n;
        logic store_strobe_n;
        logic [ADDR_W-1:0] addr;
    } sfpc_pins_t;
endpackage

// >>> verilog/sfpc_host.sv
`timescale 1ns/1ps
// ============================================================
// Host controller for a sector-program flash
// ============================================================
module sfpc_host
    import sfpc_pkg::*;
#(
    parameter int PROG_CYCLES = sfpc_pkg::PROG_CYCLE_CYC,
    parameter int POWER_CYCLES = sfpc_pkg::POWER_UP_CYC,
    parameter int WINDOW_CYCLES = sfpc_pkg::LOAD_WINDOW_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire sfpc_pkg::sfpc_req_t req,
    input wire logic req_valid,
    output logic req_ready,
    output logic [sfpc_pkg::DATA_W-1:0] rsp_data,
    output logic rsp_valid,
    output logic done_pulse,
    output logic busy,
    output sfpc_pkg::sfpc_pins_t pins,
    input wire logic [sfpc_pkg::DATA_W-1:0] data_in,
    output logic [sfpc_pkg::DATA_W-1:0] data_out,
    output logic data_oe
);
    import sfpc_pkg::*;

    typedef enum {S_POWER, S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_RSETUP, S_RSAMPLE,
                  S_GAP, S_PROG, S_PREAD, S_PSAMPLE} sfpc_state_t;

    sfpc_state_t state_q;
    sfpc_req_t cur_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] win_q;
    logic [CNT_W-1:0] prog_q;
    logic in_window_q;
    logic [DATA_W-1:0] sync1_q;
    logic [DATA_W-1:0] sync2_q;
    logic [DATA_W-1:0] last_data_q;
    logic [ADDR_W-1:0] last_addr_q;
    logic prev_tog_q;

    // ============================================================
    // Pin synchroniser
    // ============================================================
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= data_in;
            sync2_q <= sync1_q;
        end
    end

    // ============================================================
    // Sequencer
    // ============================================================
    // Final byte of a sector parks the port until the device starts programming
    assign req_ready = ((state_q == S_IDLE) || (state_q == S_GAP && cnt_q == '0)) &&
                       !(in_window_q && (win_q == '0 || cur_q.last));
    assign busy = (state_q == S_PROG) || (state_q == S_PREAD) || (state_q == S_PSAMPLE);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= S_POWER;
            cur_q <= '0;
            cnt_q <= '0;
            win_q <= '0;
            prog_q <= '0;
            in_window_q <= 1'b0;
            last_data_q <= '0;
            last_addr_q <= '0;
            prev_tog_q <= 1'b0;
            rsp_data <= '0;
            rsp_valid <= 1'b0;
            done_pulse <= 1'b0;
            pins <= '{chip_select_n: 1'b1, output_drive_n: 1'b1, store_strobe_n: 1'b1,
                      addr: '0};
            data_out <= '0;
            data_oe <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            done_pulse <= 1'b0;
            if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
            // Window timer: programming is assumed started once it runs out
            if (in_window_q && state_q != S_SETUP && state_q != S_STROBE) begin
                if (win_q != '0) win_q <= win_q - 1'b1;
            end
            case (state_q)
                S_POWER: begin
                    // Device ignores writes until its power-up delay elapses
                    if (cnt_q == '0 && prog_q == '0) prog_q <= CNT_W'(POWER_CYCLES);
                    else if (prog_q == CNT_W'(1)) begin
                        prog_q <= '0;
                        state_q <= S_IDLE;
                    end else prog_q <= prog_q - 1'b1;
                end
                S_IDLE, S_GAP: begin
                    if (in_window_q && win_q == '0) begin
                        // Window closed by timeout: device now programs
                        in_window_q <= 1'b0;
                        prog_q <= CNT_W'(PROG_CYCLES);
                        state_q <= S_PROG;
                    end else if (req_valid && req_ready) begin
                        cur_q <= req;
                        pins.addr <= req.addr;
                        cnt_q <= CNT_W'(SETUP_CYC);
                        if (req.op == SFPC_OP_LOAD) begin
                            data_out <= req.data;
                            data_oe <= 1'b1;
                            pins.output_drive_n <= 1'b1;
                            pins.chip_select_n <= 1'b0;
                            state_q <= S_SETUP;
                        end else begin
                            data_oe <= 1'b0;
                            pins.chip_select_n <= 1'b0;
                            pins.output_drive_n <= 1'b0;
                            pins.store_strobe_n <= 1'b1;
                            cnt_q <= CNT_W'(READ_CYC);
                            state_q <= S_RSETUP;
                        end
                    end else if (state_q == S_GAP && cnt_q == '0) state_q <= S_IDLE;
                end
                S_SETUP: if (cnt_q == '0) begin
                    // Store falls last, so it latches the stable address
                    pins.store_strobe_n <= 1'b0;
                    cnt_q <= CNT_W'(STROBE_LOW_CYC);
                    state_q <= S_STROBE;
                end
                S_STROBE: if (cnt_q == '0) begin
                    // Store rises first; data still driven past it
                    pins.store_strobe_n <= 1'b1;
                    last_data_q <= cur_q.data;
                    last_addr_q <= cur_q.addr;
                    win_q <= CNT_W'(WINDOW_CYCLES);
                    in_window_q <= 1'b1;
                    cnt_q <= CNT_W'(GAP_CYC);
                    state_q <= S_HOLD;
                end
                S_HOLD: if (cnt_q == '0) begin
                    pins.chip_select_n <= 1'b1;
                    data_oe <= 1'b0;
                    cnt_q <= CNT_W'(GAP_CYC);
                    rsp_valid <= 1'b1;
                    rsp_data <= cur_q.data;
                    state_q <= S_GAP;
                end
                S_RSETUP: if (cnt_q == '0) begin
                    state_q <= S_RSAMPLE;
                    cnt_q <= CNT_W'(2);
                end
                S_RSAMPLE: if (cnt_q == '0) begin
                    rsp_data <= sync2_q;
                    rsp_valid <= 1'b1;
                    pins.chip_select_n <= 1'b1;
                    pins.output_drive_n <= 1'b1;
                    cnt_q <= CNT_W'(GAP_CYC);
                    state_q <= S_GAP;
                end
                S_PROG: begin
                    // Bus is free here; poll the last loaded location
                    if (prog_q != '0) prog_q <= prog_q - 1'b1;
                    if (cnt_q == '0) begin
                        pins.addr <= last_addr_q;
                        pins.chip_select_n <= 1'b0;
                        pins.output_drive_n <= 1'b0;
                        cnt_q <= CNT_W'(READ_CYC);
                        state_q <= S_PREAD;
                    end
                end
                S_PREAD: begin
                    if (prog_q != '0) prog_q <= prog_q - 1'b1;
                    if (cnt_q == '0) begin
                        cnt_q <= CNT_W'(2);
                        state_q <= S_PSAMPLE;
                    end
                end
                S_PSAMPLE: begin
                    if (prog_q != '0) prog_q <= prog_q - 1'b1;
                    if (cnt_q == '0) begin
                        pins.chip_select_n <= 1'b1;
                        pins.output_drive_n <= 1'b1;
                        prev_tog_q <= sync2_q[TOGGLE_BIT];
                        // Done when true data is back and toggling stopped, or when prog_q runs out
                        if ((sync2_q[POLL_BIT] == last_data_q[POLL_BIT] &&
                             sync2_q[TOGGLE_BIT] == prev_tog_q) || prog_q == '0) begin
                            done_pulse <= 1'b1;
                            prog_q <= '0;
                            cnt_q <= CNT_W'(GAP_CYC);
                            state_q <= S_GAP;
                        end else begin
                            cnt_q <= CNT_W'(GAP_CYC);
                            state_q <= S_PROG;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ============================================================
    // Checks
    // ============================================================
    property p_read_float;
        @(posedge clk) disable iff (!reset_n)
        (!pins.output_drive_n && !pins.chip_select_n) |-> (!data_oe && pins.store_strobe_n);
    endproperty
    a_read_float: assert property (p_read_float) else $error("Data driven during read");

    property p_load_cond;
        @(posedge clk) disable iff (!reset_n)
        $fell(pins.store_strobe_n) |-> (!pins.chip_select_n && pins.output_drive_n && data_oe);
    endproperty
    a_load_cond: assert property (p_load_cond) else $error("Bad load strobe");

    property p_addr_stable;
        @(posedge clk) disable iff (!reset_n)
        !pins.store_strobe_n |-> $stable(pins.addr);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("Address moved in strobe");

    property p_data_hold;
        @(posedge clk) disable iff (!reset_n)
        $rose(pins.store_strobe_n) |-> data_oe ##1 data_oe;
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("Data not held");

    property p_window;
        @(posedge clk) disable iff (!reset_n)
        (in_window_q && state_q == S_IDLE && win_q == '0) |=> (state_q == S_PROG);
    endproperty
    a_window: assert property (p_window) else $error("Window expiry missed");

    property p_no_load_busy;
        @(posedge clk) disable iff (!reset_n)
        busy |-> pins.store_strobe_n;
    endproperty
    a_no_load_busy: assert property (p_no_load_busy) else $error("Load while busy");

    property p_power;
        @(posedge clk) disable iff (!reset_n)
        (state_q == S_POWER) |-> pins.store_strobe_n;
    endproperty
    a_power: assert property (p_power) else $error("Write before power delay");

    property p_strobe_len;
        @(posedge clk) disable iff (!reset_n)
        $fell(pins.store_strobe_n) |-> !pins.store_strobe_n [*8];
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("Strobe too short");
endmodule

// >>> tb/sfpc_flash_model.sv
`timescale 1ns/1ps
// ==========
// Behavioural sector flash on the host pins
module sfpc_flash_model
    import sfpc_pkg::*;
#(
    parameter int WINDOW_NS = 500,
    parameter int PROG_NS = 1000,
    parameter int POWER_NS = 100,
    parameter bit GUARD = 1'b0,
    parameter bit LOCK_LO = 1'b0,
    parameter bit LOCK_HI = 1'b0,
    parameter bit ID_MODE = 1'b0
) (
    input wire sfpc_pkg::sfpc_pins_t pins,
    input wire logic [sfpc_pkg::DATA_W-1:0] bus_in,
    output logic [sfpc_pkg::DATA_W-1:0] bus_out,
    output int viol_count
);
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] page [int];
    logic [ADDR_W-1:0] la;
    logic [SECT_W-1:0] sect = '0;
    logic [DATA_W-1:0] last_d = '0;
    logic busy_q = 1'b0;
    logic tog_q = 1'b0;
    logic ready_q = 1'b0;
    realtime fall_t = 0;
    realtime rise_t = 0;
    int key;
    wire ld = !pins.chip_select_n && !pins.store_strobe_n && pins.output_drive_n;
    wire rd = !pins.chip_select_n && !pins.output_drive_n && pins.store_strobe_n;
    function automatic logic [7:0] look(input int k);
        return mem.exists(k) ? mem[k] : 8'hff;
    endfunction
    localparam int BOOT_SZ = 8192;
    localparam int ARRAY_SZ = 262144;
    function automatic bit locked(input int k);
        return (LOCK_LO && k < BOOT_SZ) || (LOCK_HI && k >= ARRAY_SZ - BOOT_SZ);
    endfunction
    initial viol_count = 0;
    initial bus_out = 8'h00;
    initial #POWER_NS ready_q = 1'b1;
    always @(negedge pins.store_strobe_n)
        if (pins.chip_select_n || !pins.output_drive_n) viol_count++;
    always @(pins.addr) if (ld) viol_count++;
    always @(posedge ld) begin
        fall_t = $realtime;
        la = pins.addr;
    end
    always @(negedge ld)
        if ($realtime - fall_t >= 15 && ready_q && !busy_q) begin
            page[int'(la[OFFS_W-1:0])] = bus_in;
            sect = la[ADDR_W-1:OFFS_W];
            last_d = bus_in;
            rise_t = $realtime;
        end
    // Window closes only on the inactivity timeout
    always begin
        #10;
        if (page.num() != 0 && !ld && ($realtime - rise_t >= WINDOW_NS)) begin
            busy_q = 1'b1;
            #PROG_NS;
            for (int i = 0; i < 256; i++) begin
                key = {sect, i[7:0]};
                // Guarded writes and locked blocks only run the timer
                if (!GUARD && !locked(key))
                    mem[key] = page.exists(i) ? page[i] : ~look(key);
            end
            page.delete();
            busy_q = 1'b0;
        end
    end
    always @(posedge rd) if (busy_q) tog_q = ~tog_q;
    always @(rd, pins.addr, busy_q, tog_q)
        if (!rd) bus_out = ~bus_out;
        else if (busy_q) bus_out = {~last_d[7], tog_q, last_d[5:0]};
        else if (ID_MODE && (pins.addr == LOW_LOCK_ADDR || pins.addr == HIGH_LOCK_ADDR))
            bus_out = locked(int'(pins.addr)) ? LOCK_SET_VAL : LOCK_OPEN_VAL;
        else bus_out = look(int'(pins.addr));
endmodule

// >>> tb/test_sector_flash_program_control.sv
`timescale 1ns/1ps
module test_sector_flash_program_control;
    import sfpc_pkg::*;
    localparam int WIN = 50;
    localparam int DEV_PROG = 100;
    localparam logic [ADDR_W-1:0] HIGH_BOOT = 18'h3e000;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    sfpc_req_t req = '0;
    logic req_valid = 1'b0;
    logic req_ready, rsp_valid, done_pulse, busy, data_oe;
    logic [DATA_W-1:0] rsp_data, data_out, dev_data, bus, rd_q;
    logic [ADDR_W-1:0] a;
    sfpc_pins_t pins;
    int err_count = 0;
    int checks_done = 0;
    int viol_count, nb, tot;
    int ref_mem [int];
    logic [31:0] seed = 32'd99842;
    always #5 clk = ~clk;
    assign bus = data_oe ? data_out : dev_data;
    sfpc_host #(.PROG_CYCLES(200), .POWER_CYCLES(10), .WINDOW_CYCLES(WIN)) i_dut (
        .clk(clk), .reset_n(reset_n), .req(req), .req_valid(req_valid),
        .req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
        .done_pulse(done_pulse), .busy(busy), .pins(pins), .data_in(bus),
        .data_out(data_out), .data_oe(data_oe));
    sfpc_flash_model #(.WINDOW_NS(WIN * 10), .PROG_NS(DEV_PROG * 10),
        .LOCK_HI(1'b1)) i_flash (
        .pins(pins), .bus_in(bus), .bus_out(dev_data), .viol_count(viol_count));
    // ==========
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic xfer(input sfpc_op_t op, input logic [ADDR_W-1:0] ad,
                        input logic [DATA_W-1:0] d, input logic lst);
        int t;
        t = 0;
        @(negedge clk);
        req = '{op: op, addr: ad, data: d, last: lst};
        req_valid = 1'b1;
        #1;
        while (req_ready !== 1'b1 && t < 5000) begin
            @(negedge clk);
            #1;
            t++;
        end
        @(negedge clk);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && t < 5100) begin
            @(negedge clk);
            t++;
        end
        chk("handshake", 1, t < 5000);
        rd_q = rsp_data;
    endtask
    task automatic rd_chk(input logic [ADDR_W-1:0] ad);
        xfer(SFPC_OP_READ, ad, 8'h00, 1'b0);
        chk("read data", ref_mem.exists(int'(ad)) ? ref_mem[int'(ad)] : 32'hff, rd_q);
    endtask
    task automatic wait_done(output int n, output int t);
        n = 0;
        t = 0;
        while (done_pulse !== 1'b1 && t < 5000) begin
            @(negedge clk);
            t++;
            if (busy === 1'b1) n++;
        end
        chk("done pulse", 1, done_pulse === 1'b1);
    endtask
    // ==========
    // Scenarios
    initial begin
        repeat (5) @(negedge clk);
        chk("idle strobes", 3'b111, {pins.chip_select_n, pins.output_drive_n,
            pins.store_strobe_n});
        chk("data drive in reset", 0, data_oe);
        reset_n = 1'b1;
        rd_chk(18'h00005);
        for (int i = 0; i < 256; i++) begin
            seed = lfsr(seed);
            a = {10'd5, 8'(i * 37)};
            ref_mem[int'(a)] = seed[7:0];
            xfer(SFPC_OP_LOAD, a, seed[7:0], i == 255);
            chk("load echo", seed[7:0], rd_q);
        end
        wait_done(nb, tot);
        chk("status span", 1, nb >= DEV_PROG);
        chk("window held", 1, tot - nb >= WIN - 10 && tot - nb <= WIN);
        for (int i = 0; i < 256; i += 17) rd_chk({10'd5, 8'(i)});
        for (int i = 0; i < 2; i++) begin
            seed = lfsr(seed);
            a = {10'h3ff, i[0] ? 8'hff : 8'h00};
            // Top boot block is locked in the model, so nothing may land there
            if (a < HIGH_BOOT) ref_mem[int'(a)] = seed[7:0];
            xfer(SFPC_OP_LOAD, a, seed[7:0], 1'b0);
        end
        wait_done(nb, tot);
        chk("window held", 1, tot - nb >= WIN - 10 && tot - nb <= WIN);
        chk("status span", 1, nb >= DEV_PROG);
        rd_chk(18'h3ff00);
        rd_chk(18'h3ffff);
        chk("pin protocol", 0, viol_count);
        summarize();
    end
    initial begin
        #600000;
        err_count++;
        summarize();
    end
endmodule
